// ===== include/pwm_pkg.sv
/*
 * shared constants and types of the probe word pattern matcher.
 * assumes a 32-bit AHB-Lite register bus and a 16-bit probe word.
 */
`default_nettype none
package pwm_pkg;
    // ****************************************************************
    // widths and register offsets (byte addresses)
    // ****************************************************************
    localparam int DATA_W = 16;
    localparam int INT_W = 2;
    localparam logic [7:0] ADDR_VALUE = 8'h00;
    localparam logic [7:0] ADDR_CARE = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0c;
    localparam logic [7:0] ADDR_INT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;
    localparam logic [7:0] ADDR_COUNT = 8'h18;
    localparam logic [7:0] ADDR_READOUT = 8'h1c;
    localparam logic [7:0] ADDR_EDIT = 8'h20;
    // ****************************************************************
    // modes and field layouts
    // ****************************************************************
    typedef enum logic [1:0] {PWM_CLK_RISE, PWM_CLK_FALL, PWM_CLK_IGNORE} pwm_clk_mode_t;
    typedef enum logic [1:0] {PWM_Q_ZERO, PWM_Q_ONE, PWM_Q_ANY} pwm_qual_t;
    typedef enum logic [1:0] {PWM_RADIX_BIN, PWM_RADIX_OCT, PWM_RADIX_HEX} pwm_radix_t;
    typedef struct packed {
        logic [3:0] digit_sel;
        logic count_en;
        logic dly_sweep_b;
        logic dly_count_en;
        logic dly_start_en;
        logic trig_sweep_b;
        logic trig_en;
        pwm_radix_t radix;
        pwm_qual_t qual;
        pwm_clk_mode_t clk_mode;
    } pwm_ctrl_t;
    typedef struct packed {
        logic qual;
        logic clk;
        logic [DATA_W-1:0] data;
    } pwm_probe_t;
    localparam int PROBE_W = DATA_W + 2;
    localparam logic [15:0] CTRL_RESET = 16'h000a;
    localparam logic [15:0] CARE_RESET = 16'h0000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam int INT_MATCH = 0;
    localparam int INT_TRIG = 1;
    // digit readout codes and edit register fields
    localparam logic [4:0] DIGIT_X = 5'h10;
    localparam logic [4:0] DIGIT_AMBIG = 5'h11;
    localparam int EDIT_IDX_LSB = 8;
    localparam int BIN_W = 1;
    localparam int OCT_W = 3;
    localparam int HEX_W = 4;
    localparam int BIN_N = 16;
    localparam int OCT_N = 6;
    localparam int HEX_N = 4;
endpackage : pwm_pkg
`default_nettype wire

// ===== hdl/pwm_sync.sv
/*
 * two flip-flop synchroniser, one chain per bit.
 * assumes asynchronous inputs; the first stage is read only by the second.
 */
`timescale 1ns/10ps
`default_nettype none
module pwm_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    // ****************************************************************
    // per-bit chains
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_reg;
            logic stable_reg;
            // two stages keep metastability away from the compare logic
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end else begin
                    meta_reg <= async_i[g];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_o[g] = stable_reg;
        end
    endgenerate
endmodule : pwm_sync
`default_nettype wire

// ===== hdl/pwm_matcher.sv
/*
 * probe word pattern matcher: 16 data bits plus qualifier compared with a
 * programmable 0/1/don't-care word, clocked by a probe edge or free running.
 * assumes a single 50 MHz system clock, AHB-Lite single word transfers and
 * probe pins that are asynchronous to the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pwm_matcher (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [7:0] PROBE_DATA_LO_I,
    input wire logic PROBE_CLK_I,
    input wire logic [7:0] PROBE_DATA_HI_I,
    input wire logic PROBE_QUAL_I,
    output logic WORD_MATCH_O,
    output logic SWEEP_A_TRIG_O,
    output logic SWEEP_B_TRIG_O,
    output logic DELAY_START_O,
    output logic DELAY_COUNT_O,
    output logic DELAY_SWEEP_B_O,
    output logic EVENT_COUNT_O,
    output logic IRQ_O
);
    // ****************************************************************
    // digit helpers
    // ****************************************************************
    // bits per digit for a radix; illegal radix code yields no digits
    function automatic int digit_width(pwm_pkg::pwm_radix_t r);
        unique case (r)
            pwm_pkg::PWM_RADIX_BIN: return pwm_pkg::BIN_W;
            pwm_pkg::PWM_RADIX_OCT: return pwm_pkg::OCT_W;
            pwm_pkg::PWM_RADIX_HEX: return pwm_pkg::HEX_W;
            default: return 0;
        endcase
    endfunction : digit_width

    function automatic int digit_count(pwm_pkg::pwm_radix_t r);
        unique case (r)
            pwm_pkg::PWM_RADIX_BIN: return pwm_pkg::BIN_N;
            pwm_pkg::PWM_RADIX_OCT: return pwm_pkg::OCT_N;
            pwm_pkg::PWM_RADIX_HEX: return pwm_pkg::HEX_N;
            default: return 0;
        endcase
    endfunction : digit_count

    // pattern bits covered by one digit, counted from the least significant
    function automatic logic [15:0] digit_mask(pwm_pkg::pwm_radix_t r, logic [3:0] idx);
        int w;
        w = digit_width(r);
        if (int'(idx) >= digit_count(r)) begin
            return 16'h0000;
        end
        return 16'(((1 << w) - 1) << (int'(idx) * w));
    endfunction : digit_mask

    // readout code of one digit: value, all don't-care, or ambiguous
    function automatic logic [4:0] digit_code(logic [15:0] val, logic [15:0] care,
                                              pwm_pkg::pwm_radix_t r, logic [3:0] idx);
        logic [15:0] m;
        m = digit_mask(r, idx);
        if (m == 16'h0000) begin
            return 5'h00;
        end else if ((care & m) == 16'h0000) begin
            return pwm_pkg::DIGIT_X;
        end else if ((care & m) != m) begin
            return pwm_pkg::DIGIT_AMBIG;
        end
        return 5'(((val & m) >> (int'(idx) * digit_width(r))));
    endfunction : digit_code

    // ****************************************************************
    // probe inputs
    // ****************************************************************
    pwm_pkg::pwm_probe_t probe_raw;
    pwm_pkg::pwm_probe_t probe_s;
    logic [pwm_pkg::PROBE_W-1:0] probe_sync;
    // low group carries bits 0-7 and clock, high group bits 8-15 and qualifier
    assign probe_raw.data = {PROBE_DATA_HI_I, PROBE_DATA_LO_I};
    assign probe_raw.clk = PROBE_CLK_I;
    assign probe_raw.qual = PROBE_QUAL_I;

    pwm_sync #(
        .W(pwm_pkg::PROBE_W)
    ) u_sync (
        .clk_i(CLK_SYS_I),
        .rstn_i(RSTN_I),
        .async_i(probe_raw),
        .sync_o(probe_sync)
    );
    assign probe_s = pwm_pkg::pwm_probe_t'(probe_sync);

    // ****************************************************************
    // registers and bus state
    // ****************************************************************
    logic [15:0] value_reg;
    logic [15:0] care_reg;
    pwm_pkg::pwm_ctrl_t ctrl_reg;
    logic [pwm_pkg::INT_W-1:0] int_stat_reg;
    logic [pwm_pkg::INT_W-1:0] int_stat_next;
    logic [pwm_pkg::INT_W-1:0] int_mask_reg;
    logic [31:0] count_reg;
    logic [pwm_pkg::DATA_W-1:0] word_cap_reg;
    logic qual_cap_reg;
    logic clk_prev_reg;
    logic match_reg;
    logic trig_a_reg;
    logic trig_b_reg;
    logic dly_start_reg;
    logic dly_count_reg;
    logic evt_count_reg;
    logic irq_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [7:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic take;
    logic wr_hit;
    logic [4:0] edit_code;
    logic [3:0] edit_idx;
    logic [15:0] edit_mask;
    logic [15:0] edit_bits;
    logic edit_ok;

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    assign take = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign wr_hit = wr_pend_reg;

    // address phase capture; reads get one wait state so a write just before
    // is already visible when the read data is sampled
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= take & HWRITE_I;
            rd_pend_reg <= take & ~HWRITE_I;
            if (take) begin
                addr_reg <= HADDR_I[7:0];
            end
        end
    end

    // read data and ready; unmapped offsets read zero, response always OKAY
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
        end else if (take && !HWRITE_I) begin
            hreadyout_reg <= 1'b0;
        end else if (rd_pend_reg) begin
            hreadyout_reg <= 1'b1;
            unique case (addr_reg)
                pwm_pkg::ADDR_VALUE: hrdata_reg <= {16'h0000, value_reg};
                pwm_pkg::ADDR_CARE: hrdata_reg <= {16'h0000, care_reg};
                pwm_pkg::ADDR_CTRL: hrdata_reg <= {16'h0000, ctrl_reg};
                pwm_pkg::ADDR_STAT: hrdata_reg <= {14'h0000, qual_cap_reg, word_cap_reg, match_reg};
                pwm_pkg::ADDR_INT_STAT: hrdata_reg <= {30'h0000_0000, int_stat_reg};
                pwm_pkg::ADDR_INT_MASK: hrdata_reg <= {30'h0000_0000, int_mask_reg};
                pwm_pkg::ADDR_COUNT: hrdata_reg <= count_reg;
                pwm_pkg::ADDR_READOUT: hrdata_reg <= {27'h000_0000,
                    digit_code(value_reg, care_reg, ctrl_reg.radix, ctrl_reg.digit_sel)};
                default: hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign HRDATA_O = hrdata_reg;
    assign HREADYOUT_O = hreadyout_reg;
    assign HRESP_O = 1'b0;

    // ****************************************************************
    // pattern and control registers
    // ****************************************************************
    assign edit_code = HWDATA_I[4:0];
    assign edit_idx = HWDATA_I[pwm_pkg::EDIT_IDX_LSB +: 4];
    assign edit_mask = digit_mask(ctrl_reg.radix, edit_idx);
    assign edit_bits = 16'(32'(edit_code) << (int'(edit_idx) * digit_width(ctrl_reg.radix)));
    // a digit takes X or a value that fits its radix; others are dropped
    assign edit_ok = (edit_mask != 16'h0000) && ((edit_code == pwm_pkg::DIGIT_X) ||
                     (int'(edit_code) < (1 << digit_width(ctrl_reg.radix))));

    // pattern writes, whole word or one digit at a time in the shown radix
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            value_reg <= pwm_pkg::VALUE_RESET;
            care_reg <= pwm_pkg::CARE_RESET;
        end else if (wr_hit) begin
            if (addr_reg == pwm_pkg::ADDR_VALUE) begin
                value_reg <= HWDATA_I[15:0];
            end else if (addr_reg == pwm_pkg::ADDR_CARE) begin
                care_reg <= HWDATA_I[15:0];
            end else if (addr_reg == pwm_pkg::ADDR_EDIT && edit_ok) begin
                if (edit_code == pwm_pkg::DIGIT_X) begin
                    care_reg <= care_reg & ~edit_mask;
                end else begin
                    care_reg <= care_reg | edit_mask;
                    value_reg <= (value_reg & ~edit_mask) | (edit_bits & edit_mask);
                end
            end
        end
    end

    // control word: clock mode, qualifier, radix and event routing
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctrl_reg <= pwm_pkg::pwm_ctrl_t'(pwm_pkg::CTRL_RESET);
            int_mask_reg <= '0;
        end else if (wr_hit) begin
            if (addr_reg == pwm_pkg::ADDR_CTRL) begin
                ctrl_reg <= pwm_pkg::pwm_ctrl_t'(HWDATA_I[15:0]);
            end
            if (addr_reg == pwm_pkg::ADDR_INT_MASK) begin
                int_mask_reg <= HWDATA_I[pwm_pkg::INT_W-1:0];
            end
        end
    end

    // ****************************************************************
    // compare and match
    // ****************************************************************
    logic clk_rise;
    logic clk_fall;
    logic sample_now;
    logic qual_ok;
    logic word_hit;
    logic match_evt;

    assign clk_rise = probe_s.clk & ~clk_prev_reg;
    assign clk_fall = ~probe_s.clk & clk_prev_reg;

    // qualifier condition; an illegal code is treated as don't-care
    always_comb begin
        unique case (ctrl_reg.qual)
            pwm_pkg::PWM_Q_ZERO: qual_ok = ~probe_s.qual;
            pwm_pkg::PWM_Q_ONE: qual_ok = probe_s.qual;
            default: qual_ok = 1'b1;
        endcase
    end

    // seventeen bits in all: masked data plus qualifier
    assign word_hit = (((probe_s.data ^ value_reg) & care_reg) == 16'h0000) && qual_ok;

    // selected edge only in clocked modes, every cycle otherwise
    always_comb begin
        unique case (ctrl_reg.clk_mode)
            pwm_pkg::PWM_CLK_RISE: sample_now = clk_rise;
            pwm_pkg::PWM_CLK_FALL: sample_now = clk_fall;
            default: sample_now = 1'b1;
        endcase
    end

    // a clocked word counts once per qualifying edge; free running counts
    // each fresh recognition, so a steady word is one event, not many
    assign match_evt = sample_now && word_hit &&
                       (ctrl_reg.clk_mode != pwm_pkg::PWM_CLK_IGNORE || !match_reg);

    // match level and captured word; in clocked modes output holds between probe edges, free running it follows every cycle
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            clk_prev_reg <= 1'b0;
            match_reg <= 1'b0;
            word_cap_reg <= '0;
            qual_cap_reg <= 1'b0;
        end else begin
            clk_prev_reg <= probe_s.clk;
            if (sample_now) begin
                match_reg <= word_hit;
                word_cap_reg <= probe_s.data;
                qual_cap_reg <= probe_s.qual;
            end
        end
    end

    // ****************************************************************
    // event routing
    // ****************************************************************
    // one-cycle pulses to the sweep, delay and count logic
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            trig_a_reg <= 1'b0;
            trig_b_reg <= 1'b0;
            dly_start_reg <= 1'b0;
            dly_count_reg <= 1'b0;
            evt_count_reg <= 1'b0;
        end else begin
            trig_a_reg <= match_evt & ctrl_reg.trig_en & ~ctrl_reg.trig_sweep_b;
            trig_b_reg <= match_evt & ctrl_reg.trig_en & ctrl_reg.trig_sweep_b;
            dly_start_reg <= match_evt & ctrl_reg.dly_start_en;
            dly_count_reg <= match_evt & ctrl_reg.dly_count_en;
            evt_count_reg <= match_evt & ctrl_reg.count_en;
        end
    end

    // event tally; a write clears it, an event in the same cycle still counts
    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            count_reg <= 32'h0000_0000;
        end else if (wr_hit && addr_reg == pwm_pkg::ADDR_COUNT) begin
            count_reg <= {31'h0000_0000, match_evt & ctrl_reg.count_en};
        end else if (match_evt && ctrl_reg.count_en) begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    // sticky status, write one to clear; a new event wins over the clear
    always_comb begin
        int_stat_next = int_stat_reg;
        if (wr_hit && addr_reg == pwm_pkg::ADDR_INT_STAT) begin
            int_stat_next = int_stat_reg & ~HWDATA_I[pwm_pkg::INT_W-1:0];
        end
        int_stat_next[pwm_pkg::INT_MATCH] = int_stat_next[pwm_pkg::INT_MATCH] | match_evt;
        int_stat_next[pwm_pkg::INT_TRIG] = int_stat_next[pwm_pkg::INT_TRIG] |
                                           (match_evt & ctrl_reg.trig_en);
    end

    always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            int_stat_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            irq_reg <= |(int_stat_next & int_mask_reg);
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign WORD_MATCH_O = match_reg;
    assign SWEEP_A_TRIG_O = trig_a_reg;
    assign SWEEP_B_TRIG_O = trig_b_reg;
    assign DELAY_START_O = dly_start_reg;
    assign DELAY_COUNT_O = dly_count_reg;
    assign DELAY_SWEEP_B_O = ctrl_reg.dly_sweep_b;
    assign EVENT_COUNT_O = evt_count_reg;
    assign IRQ_O = irq_reg;
endmodule : pwm_matcher
`default_nettype wire

// ===== dv/pwm_props.sv
/*
 * concurrent checks on the matcher's bus handshake and event pins.
 * assumes it is bound to pwm_matcher and runs on its one system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pwm_props (
    input wire logic CLK_SYS_I,
    input wire logic RSTN_I,
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic WORD_MATCH_O,
    input wire logic SWEEP_A_TRIG_O,
    input wire logic SWEEP_B_TRIG_O,
    input wire logic DELAY_START_O,
    input wire logic DELAY_COUNT_O,
    input wire logic EVENT_COUNT_O
);
    // ********
    // checks
    // ********
    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (!RSTN_I);
    logic taken;
    // a request is taken only when the bus is ready, as the master sees it
    assign taken = HSEL_I & HTRANS_I[1] & HREADY_I;
    // reads stall exactly one cycle, writes never stall
    chk_read_wait: assert property (taken && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (taken && HWRITE_I |=> HREADYOUT_O)
        else $error("write stalled");
    chk_resp_okay: assert property (HRESP_O == 1'b0)
        else $error("response not okay");
    // read data only moves at the end of a stalled data phase
    chk_rdata_hold: assert property (!$stable(HRDATA_O) |-> $past(HREADYOUT_O) == 1'b0)
        else $error("read data changed outside a read");
    // the two sweep starts never coincide; every event pulse stands beside a recognised word
    chk_sweep_excl: assert property (!(SWEEP_A_TRIG_O && SWEEP_B_TRIG_O))
        else $error("both sweeps started");
    chk_trig_match: assert property (SWEEP_A_TRIG_O || SWEEP_B_TRIG_O |-> WORD_MATCH_O)
        else $error("sweep start without match");
    chk_count_match: assert property (EVENT_COUNT_O |-> WORD_MATCH_O)
        else $error("count pulse without match");
    chk_delay_match: assert property (DELAY_START_O || DELAY_COUNT_O |-> WORD_MATCH_O)
        else $error("delay pulse without match");
    // one event per selected edge or per rising hit, never two in a row
    chk_pulse_single: assert property (EVENT_COUNT_O |=> !EVENT_COUNT_O)
        else $error("event pulse too long");
endmodule : pwm_props
`default_nettype wire

// ===== dv/pwm_probe_model.sv
/*
 * behavioural model of the probe on the system under test.
 * assumes the bench calls put only while no burst runs.
 */
`timescale 1ns/10ps
`default_nettype none
module pwm_probe_model (
    output logic [7:0] data_lo_o,
    output logic clk_o,
    output logic [7:0] data_hi_o,
    output logic qual_o
);
    // ********
    // probe pins
    // ********
    // clock rests low between bursts; data is settled long before any edge
    initial begin
        clk_o = 1'b0;
        put(16'h0000, 1'b0);
    end
    // low byte rides with the clock group, high byte with the qualifier
    task automatic put(input logic [15:0] w, input logic q);
        data_lo_o <= w[7:0];
        data_hi_o <= w[15:8];
        qual_o <= q;
    endtask : put
    // n probe clock periods of 160 ns, each with one rise and one fall;
    // edges land on system clock edges, so non-blocking keeps them race free
    task automatic burst(input int n);
        repeat (n) begin
            #80 clk_o <= 1'b1;
            #80 clk_o <= 1'b0;
        end
    endtask : burst
endmodule : pwm_probe_model
`default_nettype wire

// ===== dv/testbench.sv
/*
 * self-checking bench of the matcher: bus tasks and scenario sequence.
 * assumes the checker and the probe model from this folder.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, rst_n, hsel, hwrite, hrdy, match, swa, swb, dst, dct, dsb, evc, irq;
    logic pclk, pq;
    logic [1:0] htrans;
    logic [7:0] plo, phi;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int failures, cmp_count, cyc;
    int np [5];
    // {ctrl, expected readout code}: hex, octal and binary digits
    logic [31:0] ro [7] = '{32'h0022_0011, 32'h1022_000a, 32'h2022_0010, 32'h0012_0005,
        32'h1012_0011, 32'h3002_0010, 32'h0002_0001};
    // ********
    // clock, parts and monitors
    // ********
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    pwm_probe_model probe (.data_lo_o(plo), .clk_o(pclk), .data_hi_o(phi), .qual_o(pq));
    pwm_matcher dut (.CLK_SYS_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(),
        .PROBE_DATA_LO_I(plo), .PROBE_CLK_I(pclk), .PROBE_DATA_HI_I(phi),
        .PROBE_QUAL_I(pq), .WORD_MATCH_O(match), .SWEEP_A_TRIG_O(swa),
        .SWEEP_B_TRIG_O(swb), .DELAY_START_O(dst), .DELAY_COUNT_O(dct),
        .DELAY_SWEEP_B_O(dsb), .EVENT_COUNT_O(evc), .IRQ_O(irq));
    // pulse tallies and the hang guard
    always @(posedge clk) begin
        np[0] += int'(swa === 1'b1);
        np[1] += int'(swb === 1'b1);
        np[2] += int'(dst === 1'b1);
        np[3] += int'(dct === 1'b1);
        np[4] += int'(evc === 1'b1);
        cyc++;
        if (cyc == 4000) begin
            failures++;
            conclude();
        end
    end
    // ********
    // tasks
    // ********
    // one single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    // pins reach the match flop three edges late, so give them six edges
    task automatic pin(input logic exp);
        repeat (6) @(posedge clk);
        chk({31'h0, match}, {31'h0, exp});
    endtask : pin
    task automatic conclude;
        $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    // ********
    // scenarios
    // ********
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rchk(pwm_pkg::ADDR_CTRL, 32'h000a);
        rchk(pwm_pkg::ADDR_CARE, 32'h0);
        rchk(8'h40, 32'h0);
        pin(1'b1);
        $display("reset test done");
        // free running compare with a qualifier of one, then of zero
        wr(pwm_pkg::ADDR_VALUE, 32'ha5c3);
        wr(pwm_pkg::ADDR_CARE, 32'hffff);
        wr(pwm_pkg::ADDR_CTRL, 32'h0006);
        probe.put(16'ha5c3, 1'b1);
        pin(1'b1);
        probe.put(16'ha5c3, 1'b0);
        pin(1'b0);
        probe.put(16'ha5c2, 1'b1);
        pin(1'b0);
        rchk(pwm_pkg::ADDR_STAT, 32'h34b84);
        wr(pwm_pkg::ADDR_CARE, 32'hfffe);
        pin(1'b1);
        wr(pwm_pkg::ADDR_CTRL, 32'h0002);
        pin(1'b0);
        probe.put(16'ha5c2, 1'b0);
        pin(1'b1);
        $display("level test done");
        // rising then falling edge mode, all event uses on, sweep a then b
        for (int m = 0; m < 2; m++) begin
            wr(pwm_pkg::ADDR_CTRL, 32'h000a);
            probe.put(16'h0000, 1'b0);
            pin(1'b0);
            wr(pwm_pkg::ADDR_CTRL, m ? 32'h0fc9 : 32'h0b48);
            wr(pwm_pkg::ADDR_COUNT, 32'h0);
            wr(pwm_pkg::ADDR_INT_STAT, 32'h3);
            probe.put(16'ha5c3, 1'b0);
            pin(1'b0);
            np = '{default: 0};
            probe.burst(3);
            pin(1'b1);
            rchk(pwm_pkg::ADDR_COUNT, 32'h3);
            chk(np[0], m ? 0 : 3);
            chk(np[1], m ? 3 : 0);
            chk({8'h00, np[2][7:0], np[3][7:0], np[4][7:0]}, 32'h0003_0303);
            chk({31'h0, dsb}, m);
            probe.put(16'h0000, 1'b0);
            probe.burst(1);
            pin(1'b0);
        end
        $display("edge test done");
        // sticky events, mask and write-one clear
        rchk(pwm_pkg::ADDR_INT_STAT, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(pwm_pkg::ADDR_INT_MASK, 32'h1);
        rchk(pwm_pkg::ADDR_INT_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(pwm_pkg::ADDR_INT_STAT, 32'h1);
        rchk(pwm_pkg::ADDR_INT_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(pwm_pkg::ADDR_INT_MASK, 32'h3);
        rchk(pwm_pkg::ADDR_INT_STAT, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(pwm_pkg::ADDR_INT_STAT, 32'h2);
        rchk(pwm_pkg::ADDR_INT_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        // digit readout in every radix, then the digit editor
        wr(pwm_pkg::ADDR_VALUE, 32'h00a5);
        wr(pwm_pkg::ADDR_CARE, 32'h00f7);
        for (int i = 0; i < 7; i++) begin
            wr(pwm_pkg::ADDR_CTRL, {16'h0, ro[i][31:16]});
            rchk(pwm_pkg::ADDR_READOUT, {16'h0, ro[i][15:0]});
        end
        wr(pwm_pkg::ADDR_CTRL, 32'h0022);
        wr(pwm_pkg::ADDR_EDIT, 32'h030f);
        wr(pwm_pkg::ADDR_EDIT, 32'h0012);
        rchk(pwm_pkg::ADDR_VALUE, 32'hf0a5);
        rchk(pwm_pkg::ADDR_CARE, 32'hf0f7);
        wr(pwm_pkg::ADDR_CTRL, 32'h0012);
        wr(pwm_pkg::ADDR_EDIT, 32'h0008);
        wr(pwm_pkg::ADDR_CTRL, 32'h0002);
        wr(pwm_pkg::ADDR_EDIT, 32'h0002);
        wr(pwm_pkg::ADDR_EDIT, 32'h0801);
        rchk(pwm_pkg::ADDR_VALUE, 32'hf1a5);
        wr(pwm_pkg::ADDR_EDIT, 32'h0010);
        rchk(pwm_pkg::ADDR_CARE, 32'hf1f6);
        $display("digit test done");
        conclude();
    end
endmodule : testbench
bind pwm_matcher pwm_props u_props (.CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .WORD_MATCH_O(WORD_MATCH_O),
    .SWEEP_A_TRIG_O(SWEEP_A_TRIG_O), .SWEEP_B_TRIG_O(SWEEP_B_TRIG_O),
    .DELAY_START_O(DELAY_START_O), .DELAY_COUNT_O(DELAY_COUNT_O),
    .EVENT_COUNT_O(EVENT_COUNT_O));
`default_nettype wire
